// *** logic/pic_top.sv ***
// pulse input counter: total, interval quantity, rate and scaled values
// assumes all strobes come from logic on mclk_in; only the sensor pin is async
`timescale 1ns/1ps
module pic_top #(
  parameter int unsigned DEB_CYCLES = pic_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned SEC_CYCLES = pic_pkg::SECOND_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic pulse_pin_in,
  input wire pic_pkg::pic_cfg_t cfg_in,
  input wire logic count_load_in,
  input wire logic [31:0] count_load_value_in,
  input wire logic rtc_midnight_in,
  input wire logic log_boundary_in,
  output logic pull_up_en_out,
  output logic pull_down_en_out,
  output logic pulse_event_out,
  output logic [31:0] count_out,
  output logic [31:0] quantity_out,
  output logic [31:0] quantity_stored_out,
  output logic [47:0] count_units_out,
  output logic [47:0] quantity_units_out,
  output logic [31:0] rate_out,
  output logic rate_valid_out,
  output logic log_entry_out
);
  logic pulse;
  logic clear;
  logic [31:0] count_next;
  logic [31:0] sec_cnt_reg;
  logic have_prev_reg;
  logic sec_tick;
  logic [31:0] tick_cnt_reg;
  pic_pkg::pic_div_state_t div_state_reg;
  logic [5:0] div_step_reg;
  logic [31:0] num_reg;
  logic [31:0] den_reg;
  logic [32:0] rem_reg;
  logic [31:0] quo_reg;
  logic [32:0] rem_shift;

  pic_debounce #(
    .DEB_CYCLES(DEB_CYCLES)
  ) u_debounce (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pin_in(pulse_pin_in),
    .pull_up_in(cfg_in.pull_up),
    .pulse_out(pulse)
  );

  // one pull at a time, never both
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      // pull-down until the configuration is taken
      pull_up_en_out <= 1'b0;
      pull_down_en_out <= 1'b1;
    end else begin
      pull_up_en_out <= cfg_in.pull_up;
      pull_down_en_out <= ~cfg_in.pull_up;
    end
  end

  // wake/interrupt strobe toward the sleeping logger
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pulse_event_out <= 1'b0;
    end else begin
      pulse_event_out <= pulse;
    end
  end

  assign clear = count_load_in | (cfg_in.midnight_en & rtc_midnight_in);

  // a pulse in the clearing cycle is kept: it counts on top of the new value
  always_comb begin
    count_next = count_out;
    if (count_load_in) begin
      count_next = count_load_value_in;
    end else if (cfg_in.midnight_en && rtc_midnight_in) begin
      count_next = pic_pkg::COUNT_RESET;
    end
    if (pulse) begin
      count_next = count_next + 32'h0000_0001;
    end
  end

  // no power-state input exists here: this domain stays up on the backup cell
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      count_out <= pic_pkg::COUNT_RESET;
    end else begin
      count_out <= count_next;
    end
  end

  // interval quantity, kept as its own counter so a counter clear cannot go negative
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      quantity_out <= 32'h0000_0000;
      quantity_stored_out <= 32'h0000_0000;
    end else if (log_boundary_in) begin
      quantity_stored_out <= quantity_out;
      quantity_out <= pulse ? 32'h0000_0001 : 32'h0000_0000;
    end else if (pulse) begin
      quantity_out <= quantity_out + 32'h0000_0001;
    end
  end

  // scaled values trail count and quantity by one cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      count_units_out <= 48'h0000_0000_0000;
      quantity_units_out <= 48'h0000_0000_0000;
    end else begin
      count_units_out <= 48'(count_out) * 48'(cfg_in.units_per_pulse);
      quantity_units_out <= 48'(quantity_out) * 48'(cfg_in.units_per_pulse);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      log_entry_out <= 1'b0;
    end else begin
      log_entry_out <= log_boundary_in
        | (cfg_in.log_each_change & (count_next != count_out));
    end
  end

  // one-second enable for the rate timebase
  assign sec_tick = (tick_cnt_reg == SEC_CYCLES - 1);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || sec_tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // seconds since last pulse, saturating; a zero gap is treated as one second
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sec_cnt_reg <= 32'h0000_0000;
      have_prev_reg <= 1'b0;
    end else if (pulse) begin
      sec_cnt_reg <= 32'h0000_0000;
      have_prev_reg <= 1'b1;
    end else if (sec_tick && sec_cnt_reg != pic_pkg::COUNT_MAX) begin
      sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
    end
  end

  // serial divide: units_per_pulse * 3600 / gap; a new pulse restarts it
  assign rem_shift = {rem_reg[31:0], num_reg[31]};

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      div_state_reg <= pic_pkg::DIV_IDLE;
      div_step_reg <= 6'h00;
      num_reg <= 32'h0000_0000;
      den_reg <= 32'h0000_0001;
      rem_reg <= 33'h0_0000_0000;
      quo_reg <= 32'h0000_0000;
    end else if (pulse && have_prev_reg) begin
      div_state_reg <= pic_pkg::DIV_RUN;
      div_step_reg <= 6'h00;
      // full 28-bit product: a 16-bit self-sized product would lose the top bits
      num_reg <= {4'h0, 28'(cfg_in.units_per_pulse) * 28'(pic_pkg::SECONDS_PER_HOUR)};
      den_reg <= (sec_cnt_reg == 32'h0000_0000) ? 32'h0000_0001 : sec_cnt_reg;
      rem_reg <= 33'h0_0000_0000;
      quo_reg <= 32'h0000_0000;
    end else begin
      case (div_state_reg)
        pic_pkg::DIV_RUN: begin
          num_reg <= {num_reg[30:0], 1'b0};
          if (rem_shift >= {1'b0, den_reg}) begin
            rem_reg <= rem_shift - {1'b0, den_reg};
            quo_reg <= {quo_reg[30:0], 1'b1};
          end else begin
            rem_reg <= rem_shift;
            quo_reg <= {quo_reg[30:0], 1'b0};
          end
          div_step_reg <= div_step_reg + 6'h01;
          if (div_step_reg == pic_pkg::DIV_STEPS - 6'h01) begin
            div_state_reg <= pic_pkg::DIV_DONE;
          end
        end
        pic_pkg::DIV_DONE: begin
          div_state_reg <= pic_pkg::DIV_IDLE;
        end
        default: begin
          div_state_reg <= pic_pkg::DIV_IDLE;
        end
      endcase
    end
  end

  // rate holds its last value until the next pulse pair completes
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rate_out <= 32'h0000_0000;
      rate_valid_out <= 1'b0;
    end else if (div_state_reg == pic_pkg::DIV_DONE && !(pulse && have_prev_reg)) begin
      rate_out <= quo_reg;
      rate_valid_out <= 1'b1;
    end
  end

  a_count_step: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pulse && !clear |=> count_out == $past(count_out) + 32'h0000_0001)
    else $error("counter did not step on pulse");

  a_count_wrap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pulse && !clear && count_out == 32'hFFFF_FFFF |=> count_out == 32'h0000_0000)
    else $error("counter did not wrap");

  a_zero_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    count_load_in && count_load_value_in == 32'h0000_0000 && !pulse
      |=> count_out == 32'h0000_0000)
    else $error("zero write did not clear counter");

  a_midnight_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    cfg_in.midnight_en && rtc_midnight_in && !count_load_in && !pulse
      |=> count_out == 32'h0000_0000)
    else $error("midnight did not clear counter");

  a_boundary_store: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    log_boundary_in |=> quantity_stored_out == $past(quantity_out)
      && quantity_out == {31'h0, $past(pulse)} && log_entry_out)
    else $error("boundary store or clear wrong");

  a_quantity_run: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pulse && !log_boundary_in |=> quantity_out == $past(quantity_out) + 32'h0000_0001)
    else $error("quantity did not rise with pulse");

  a_change_log: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    cfg_in.log_each_change && pulse && !clear |=> log_entry_out)
    else $error("count change not logged");

  a_rate_result: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pulse && have_prev_reg ##1 !(pulse && have_prev_reg) [*8]
      ##1 !(pulse && have_prev_reg) [*8] ##1 !(pulse && have_prev_reg) [*8]
      ##1 !(pulse && have_prev_reg) [*8] ##1 !(pulse && have_prev_reg)
      |=> rate_valid_out && rate_out == $past(quo_reg))
    else $error("rate result not delivered in time");

  a_pull_excl: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !(pull_up_en_out && pull_down_en_out) ##0 (pull_up_en_out != pull_down_en_out))
    else $error("pull selection inconsistent");

  a_pulse_event: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pulse |=> pulse_event_out)
    else $error("pulse not reported");
endmodule

// *** shared/pic_pkg.sv ***
// constants, configuration carrier and state codes for the pulse input counter
// assumes a single 50 MHz always-on clock feeding every user of this package
package pic_pkg;
  localparam int unsigned MCLK_PERIOD_NS = 20;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned UPP_W = 16;
  localparam int unsigned UNITS_W = CNT_W + UPP_W;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_MAX = 32'hFFFF_FFFF;
  // contact bounce settle time, a least time, rounded up
  localparam int unsigned DEBOUNCE_TIME_US = 5000;
  localparam int unsigned DEBOUNCE_CYCLES =
    (DEBOUNCE_TIME_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // rate timebase
  localparam int unsigned SECOND_TIME_MS = 1000;
  localparam int unsigned SECOND_CYCLES = (SECOND_TIME_MS * 1000000) / MCLK_PERIOD_NS;
  localparam logic [11:0] SECONDS_PER_HOUR = 12'hE10;
  localparam logic [5:0] DIV_STEPS = 6'h20;

  typedef struct packed {
    logic pull_up;
    logic midnight_en;
    logic log_each_change;
    logic [15:0] units_per_pulse;
  } pic_cfg_t;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN = 2'b01,
    DIV_DONE = 2'b10
  } pic_div_state_t;
endpackage

// *** logic/pic_debounce.sv ***
// synchroniser, contact debouncer and active-edge detector for the pulse pin
// assumes the pin is asynchronous to mclk_in and idles at its pull level
`timescale 1ns/1ps
module pic_debounce #(
  parameter int unsigned DEB_CYCLES = pic_pkg::DEBOUNCE_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic pull_up_in,
  output logic pulse_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic stable_reg;
  logic active_prev_reg;
  logic [31:0] deb_cnt_reg;
  logic active;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a level must agree on s2/s3 and hold for the settle time before it counts
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      stable_reg <= 1'b0;
      deb_cnt_reg <= 32'h0000_0000;
    end else if (s2_reg == s3_reg && s3_reg != stable_reg) begin
      if (deb_cnt_reg >= DEB_CYCLES - 1) begin
        stable_reg <= s3_reg;
        deb_cnt_reg <= 32'h0000_0000;
      end else begin
        deb_cnt_reg <= deb_cnt_reg + 32'h0000_0001;
      end
    end else begin
      deb_cnt_reg <= 32'h0000_0000;
    end
  end

  // switch to ground with pull-up means active low
  assign active = pull_up_in ? ~stable_reg : stable_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      // seen as already active: a pull-up idle level must not give an edge
      active_prev_reg <= 1'b1;
      pulse_out <= 1'b0;
    end else begin
      active_prev_reg <= active;
      pulse_out <= active & ~active_prev_reg;
    end
  end

  a_pulse_single: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pulse_out |=> !pulse_out)
    else $error("pulse output longer than one cycle");
endmodule

// *** dv/pic_reed_model.sv ***
// reed switch pulse sensor model on the pulse pin
// assumes the device pull enables set the idle level of the pin
`timescale 1ns/1ps
module pic_reed_model (
  input wire logic mclk_in,
  input wire logic pull_up_en_in,
  input wire logic pull_down_en_in,
  output logic pin_out
);
  logic closed_reg = 1'b0;
  logic float_reg = 1'b0;
  // switch to ground under pull-up, to supply under pull-down
  always_comb begin
    if (closed_reg) begin
      pin_out = !pull_up_en_in;
    end else if (pull_up_en_in) begin
      pin_out = 1'b1;
    end else if (pull_down_en_in) begin
      pin_out = 1'b0;
    end else begin
      pin_out = float_reg;
    end
  end
  // an unpulled pin must not look like a clean level
  always @(posedge mclk_in) begin
    float_reg <= ~float_reg;
  end
  task automatic tip(input int hold, input int gap);
    @(negedge mclk_in);
    closed_reg = 1'b1;
    repeat (hold) @(negedge mclk_in);
    closed_reg = 1'b0;
    repeat (gap) @(negedge mclk_in);
  endtask
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the pulse input counter
// assumes the reed model on the pin, debounce of 4 and a second of 20 cycles
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  pic_pkg::pic_cfg_t cfg;
  logic load = 1'b0;
  logic [31:0] load_val = 32'h0000_0000;
  logic midnight = 1'b0;
  logic bound = 1'b0;
  logic pin, pu, pd, evt, rv, le;
  logic [31:0] cnt, qty, qst, rate;
  logic [47:0] cu, qu;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  initial begin
    forever #10 mclk = ~mclk;
  end
  pic_top #(.DEB_CYCLES(4), .SEC_CYCLES(20)) uut (
    .mclk_in(mclk), .rst_n_in(rst_n), .pulse_pin_in(pin), .cfg_in(cfg),
    .count_load_in(load), .count_load_value_in(load_val), .rtc_midnight_in(midnight),
    .log_boundary_in(bound), .pull_up_en_out(pu), .pull_down_en_out(pd),
    .pulse_event_out(evt), .count_out(cnt), .quantity_out(qty),
    .quantity_stored_out(qst), .count_units_out(cu), .quantity_units_out(qu),
    .rate_out(rate), .rate_valid_out(rv), .log_entry_out(le));
  pic_reed_model sensor (.mclk_in(mclk), .pull_up_en_in(pu), .pull_down_en_in(pd),
    .pin_out(pin));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    // let the pull settle and the synchroniser flush
    repeat (20) @(negedge mclk);
  endtask
  task automatic strobe(input int sel);
    @(negedge mclk);
    load = (sel == 0);
    midnight = (sel == 1);
    bound = (sel == 2);
    @(negedge mclk);
    load = 1'b0;
    midnight = 1'b0;
    bound = 1'b0;
  endtask
  task automatic t_reset();
    do_reset();
    chk(pd, 1'b1);
    chk(pu, 1'b0);
    chk(cnt, 32'h0);
    chk(rv, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_count();
    // bounce shorter than the debounce window
    sensor.tip(2, 12);
    chk(cnt, 32'h0);
    for (int i = 0; i < 3; i++) begin
      sensor.tip(10, 12);
      chk(cnt, i + 1);
      chk(qty, i + 1);
    end
    chk(cu, 48'h258);
    chk(qu, 48'h258);
    $display("test count done");
  endtask
  task automatic t_bound();
    strobe(2);
    chk(le, 1'b1);
    chk(qst, 32'h3);
    chk(qty, 32'h0);
    sensor.tip(10, 12);
    chk(qty, 32'h1);
    $display("test boundary done");
  endtask
  task automatic t_load();
    load_val = 32'h0000_0000;
    strobe(0);
    chk(cnt, 32'h0);
    load_val = 32'hFFFF_FFFF;
    strobe(0);
    chk(cnt, 32'hFFFF_FFFF);
    sensor.tip(10, 12);
    chk(cnt, 32'h0);
    chk(qty, 32'h2);
    $display("test load done");
  endtask
  task automatic t_midnight();
    sensor.tip(10, 12);
    strobe(1);
    chk(cnt, 32'h1);
    cfg.midnight_en = 1'b1;
    strobe(1);
    chk(cnt, 32'h0);
    $display("test midnight done");
  endtask
  task automatic t_log();
    cfg.log_each_change = 1'b1;
    fork
      sensor.tip(10, 12);
      begin
        repeat (20) if (evt !== 1'b1) @(negedge mclk);
        chk(evt, 1'b1);
        chk(le, 1'b1);
      end
    join
    $display("test log change done");
  endtask
  task automatic t_rate();
    logic ok;
    // polarity changed under reset so no false edge is seen
    @(negedge mclk);
    rst_n = 1'b0;
    cfg.pull_up = 1'b1;
    do_reset();
    chk(pu, 1'b1);
    sensor.tip(10, 90);
    chk(rv, 1'b0);
    sensor.tip(10, 60);
    chk(cnt, 32'h2);
    chk(rv, 1'b1);
    // 200 per pulse over 5 s, one second of quantisation either way
    ok = (rate === 32'h0002_3280) || (rate === 32'h0002_BF20) || (rate === 32'h0001_D4C0);
    chk(ok, 1'b1);
    $display("test rate done");
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    cfg.pull_up = 1'b0;
    cfg.midnight_en = 1'b0;
    cfg.log_each_change = 1'b0;
    cfg.units_per_pulse = 16'h00C8;
    t_reset();
    t_count();
    t_bound();
    t_load();
    t_midnight();
    t_log();
    t_rate();
    give_verdict();
  end
endmodule
